// ---- hw/sfg_write_guard.v ----
// Serial flash write guard: command machine, array, protection, one-time area.
// Assumes SPI pins asynchronous to i_clk (sampled, 200 MHz) and a Wishbone master.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "sfg_map.vh"
module sfg_write_guard (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   input wire i_cs_b,
   input wire i_sclk,
   input wire i_io_line0_in,
   input wire i_io_line1_in,
   input wire i_io_line2_in,
   input wire i_io_line3_in,
   output reg o_io_line0_out,
   output reg o_io_line1_out,
   output reg o_io_line2_out,
   output reg o_io_line3_out,
   output reg o_io_line0_oe,
   output reg o_io_line1_oe,
   output reg o_io_line2_oe,
   output reg o_io_line3_oe,
   output reg o_write_in_progress,
   output reg o_standby
);
   localparam P_IDLE = 3'h0;
   localparam P_OPC = 3'h1;
   localparam P_ADDR = 3'h2;
   localparam P_DUMMY = 3'h3;
   localparam P_DIN = 3'h4;
   localparam P_DOUT = 3'h5;
   localparam P_IGN = 3'h6;

   // Shift in one step of 1, 2 or 4 lines, MSB first
   function [7:0] shin;
      input [7:0] s;
      input [3:0] b;
      input [2:0] l;
      begin
         case (l)
         3'h1: shin = {s[6:0], b[0]};
         3'h2: shin = {s[5:0], b[1:0]};
         default: shin = {s[3:0], b};
         endcase
      end
   endfunction

   function prot;
      input [3:0] bp;
      input [4:0] blk;
      begin
         case (bp)
         4'h0: prot = 1'b0; // see RQ16
         4'h1: prot = blk >= 5'h1F; // see RQ14
         4'h2: prot = blk >= 5'h1E;
         4'h3: prot = blk >= 5'h1C;
         4'h4: prot = blk >= 5'h18;
         4'h5: prot = blk >= 5'h10;
         4'hA: prot = blk < 5'h10; // see RQ15
         4'hB: prot = blk < 5'h18;
         4'hC: prot = blk < 5'h1C;
         4'hD: prot = blk < 5'h1E;
         4'hE: prot = blk < 5'h1F;
         default: prot = 1'b1;
         endcase
      end
   endfunction

   reg [7:0] mem [0:`SFG_ARRAY_BYTES-1]; // see RQ1
   reg [7:0] otp [0:`SFG_OTP_BYTES-1]; // see RQ24
   reg [7:0] pbuf [0:`SFG_PAGE_BYTES-1];
   reg [5:0] s1_q;
   reg [5:0] s2_q;
   reg [1:0] prev_q;
   reg [2:0] ph_q;
   reg [2:0] lanes_q;
   reg [2:0] bitc_q;
   reg [7:0] sh_q;
   reg [7:0] opc_q;
   reg [23:0] addr_q;
   reg [1:0] abytes_q;
   reg [2:0] dcnt_q;
   reg nin_q;
   reg [7:0] sdat_q;
   reg [7:0] col_q;
   reg [3:0] ocnt_q;
   reg [7:0] osh_q;
   reg [23:0] raddr_q;
   reg latch_q;
   reg [3:0] bp_q;
   reg lock_q;
   reg otp_q;
   reg sleep_q;
   reg cust_q;
   reg fact_q;
   reg quad_en_q;
   reg busy_q;
   reg erase_q;
   reg eotp_q;
   reg [23:0] ea_q;
   reg [23:0] eend_q;
   reg [255:0] pval_q;
   reg [7:0] nxt;

   // Only the second stage of the synchroniser is looked at
   wire cs_hi = s2_q[5];
   wire rise = s2_q[4] & ~prev_q[0];
   wire fall = ~s2_q[4] & prev_q[0];
   wire cs_fall = ~s2_q[5] & prev_q[1];
   wire cs_rise = s2_q[5] & ~prev_q[1];
   wire [3:0] din = s2_q[3:0];
   wire wp_low = ~s2_q[2];
   wire [3:0] bsum = {1'b0, bitc_q} + {1'b0, lanes_q};
   wire [7:0] nb = shin(sh_q, din, lanes_q);
   wire shifting = ph_q == P_OPC || ph_q == P_ADDR || ph_q == P_DIN;
   wire step = rise & ~cs_hi & shifting;
   wire done = step & bsum[3];
   wire [7:0] stat = {lock_q, 1'b0, bp_q, latch_q, busy_q};
   wire [23:0] full_addr = {addr_q[15:0], nb};
   wire in_prot = prot(bp_q, addr_q[20:16]);
   wire pin_guard = lock_q & wp_low & ~quad_en_q;
   wire any_lock = fact_q | cust_q;
   wire exec = cs_rise & ph_q == P_DIN & bitc_q == 3'h0; // see RQ9
   wire plain = exec & ~nin_q;
   wire prog_cmd = opc_q == `SFG_PAGE_PROGRAM_CMD || opc_q == `SFG_QUAD_PAGE_PROGRAM_CMD;
   wire pb_we = done & ph_q == P_DIN & prog_cmd;
   wire ewr = busy_q & (erase_q | pval_q[ea_q[7:0]]);
   wire [7:0] ecur = eotp_q ? otp[ea_q[8:0]] : mem[ea_q[20:0]];
   wire [7:0] ewd = erase_q ? `SFG_ERASED : (ecur & pbuf[ea_q[7:0]]);
   wire [7:0] obyte = (ocnt_q == 4'h0) ? nxt : osh_q;
   wire [3:0] ocur = (ocnt_q == 4'h0) ? 4'h8 : ocnt_q;

   // Data source for the output phase
   always @* begin
      case (opc_q)
      `SFG_STATUS_READ_CMD: nxt = stat; // see RQ5
      `SFG_SECURITY_REG_READ_CMD: nxt = {6'h00, cust_q, fact_q}; // see RQ19
      `SFG_WAKE_FROM_SLEEP_CMD: nxt = `SFG_SIGNATURE;
      default: nxt = otp_q ? otp[raddr_q[8:0]] : mem[raddr_q[20:0]]; // see RQ23
      endcase
   end

   // Arrays carry no reset; the engine is the only writer of mem and otp, pbuf is filled from the link
   always @(posedge i_clk) begin
      if (ewr && !eotp_q)
         mem[ea_q[20:0]] <= ewd; // see RQ4
      if (ewr && eotp_q)
         otp[ea_q[8:0]] <= ewd; // see RQ20
      if (pb_we)
         pbuf[col_q] <= nb;
   end

   // Pin sampling and edge history
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_q <= 6'h20;
         s2_q <= 6'h20;
         prev_q <= 2'h2;
      end else begin
         s1_q <= {i_cs_b, i_sclk, i_io_line3_in, i_io_line2_in, i_io_line1_in,
                  i_io_line0_in};
         s2_q <= s1_q;
         prev_q <= s2_q[5:4];
      end
   end

   // Command machine, protection state and program/erase engine
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ph_q <= P_IDLE; // see RQ7
         lanes_q <= 3'h1;
         bitc_q <= 3'h0;
         sh_q <= 8'h00;
         opc_q <= 8'h00;
         addr_q <= 24'h000000;
         abytes_q <= 2'h0;
         dcnt_q <= 3'h0;
         nin_q <= 1'b0;
         sdat_q <= 8'h00;
         col_q <= 8'h00;
         ocnt_q <= 4'h0;
         osh_q <= 8'h00;
         raddr_q <= 24'h000000;
         latch_q <= 1'b0; // see RQ11
         bp_q <= `SFG_BP_RESET;
         lock_q <= 1'b0;
         otp_q <= 1'b0;
         sleep_q <= 1'b0;
         cust_q <= 1'b0;
         busy_q <= 1'b0;
         erase_q <= 1'b0;
         eotp_q <= 1'b0;
         ea_q <= 24'h000000;
         eend_q <= 24'h000000;
         pval_q <= 256'h0;
         o_io_line0_out <= 1'b0;
         o_io_line1_out <= 1'b0;
         o_io_line2_out <= 1'b0;
         o_io_line3_out <= 1'b0;
         o_io_line0_oe <= 1'b0;
         o_io_line1_oe <= 1'b0;
         o_io_line2_oe <= 1'b0;
         o_io_line3_oe <= 1'b0;
         o_write_in_progress <= 1'b0;
         o_standby <= 1'b1;
      end else begin
         o_write_in_progress <= busy_q; // see RQ5
         o_standby <= cs_hi & ~busy_q; // see RQ6
         if (busy_q) begin
            if (ea_q == eend_q) begin
               busy_q <= 1'b0;
               latch_q <= 1'b0; // see RQ11
            end else
               ea_q <= ea_q + 24'h000001;
         end
         if (step) begin
            sh_q <= nb; // see RQ25
            bitc_q <= bsum[2:0];
         end
         if (cs_fall && ph_q == P_IDLE) begin
            ph_q <= P_OPC;
            lanes_q <= 3'h1;
            bitc_q <= 3'h0;
            abytes_q <= 2'h0;
            nin_q <= 1'b0;
         end
         if (cs_rise) begin
            ph_q <= P_IDLE;
            o_io_line0_oe <= 1'b0;
            o_io_line1_oe <= 1'b0;
            o_io_line2_oe <= 1'b0;
            o_io_line3_oe <= 1'b0;
            if (opc_q == `SFG_WAKE_FROM_SLEEP_CMD && ph_q != P_IGN && ph_q != P_IDLE)
               sleep_q <= 1'b0; // see RQ12
         end
         // No command in the case below runs unless the whole command arrived byte-aligned
         if (exec) begin // see RQ8
            case (opc_q)
            `SFG_SET_WRITE_ENABLE_CMD: begin
               if (!nin_q)
                  latch_q <= 1'b1; // see RQ10
            end
            `SFG_CLEAR_WRITE_ENABLE_CMD: begin
               if (!nin_q)
                  latch_q <= 1'b0; // see RQ11
            end
            `SFG_STATUS_WRITE_CMD: begin
               // A pin-guarded write is refused whole, so the latch stays set
               if (nin_q && latch_q && !pin_guard) begin // see RQ28 RQ17 RQ18
                  latch_q <= 1'b0; // see RQ11
                  bp_q <= sdat_q[5:2];
                  lock_q <= sdat_q[7];
               end
            end
            `SFG_PAGE_PROGRAM_CMD, `SFG_QUAD_PAGE_PROGRAM_CMD: begin
               // Any lock freezes the whole one-time area
               if (nin_q && latch_q && (otp_q ? !any_lock : !in_prot)) begin // see RQ13 RQ22
                  busy_q <= 1'b1;
                  erase_q <= 1'b0;
                  eotp_q <= otp_q; // see RQ20
                  ea_q <= {addr_q[23:8], 8'h00};
                  eend_q <= {addr_q[23:8], 8'hFF};
               end
            end
            `SFG_FOUR_KB_WIPE_CMD, `SFG_BLOCK_WIPE_CMD: begin
               if (plain && latch_q && !otp_q && !in_prot) begin // see RQ13 RQ23
                  busy_q <= 1'b1;
                  erase_q <= 1'b1;
                  eotp_q <= 1'b0;
                  if (opc_q == `SFG_FOUR_KB_WIPE_CMD) begin
                     ea_q <= addr_q & ~`SFG_SECTOR_MASK;
                     eend_q <= addr_q | `SFG_SECTOR_MASK;
                  end else begin
                     ea_q <= addr_q & ~`SFG_BLOCK_MASK;
                     eend_q <= addr_q | `SFG_BLOCK_MASK;
                  end
               end
            end
            `SFG_CHIP_WIPE_CMD: begin
               if (plain && latch_q && !otp_q && bp_q == 4'h0) begin // see RQ16
                  busy_q <= 1'b1;
                  erase_q <= 1'b1;
                  eotp_q <= 1'b0;
                  ea_q <= 24'h000000;
                  eend_q <= `SFG_CHIP_LAST;
               end
            end
            `SFG_DEEP_SLEEP_CMD: begin
               if (plain)
                  sleep_q <= 1'b1;
            end
            `SFG_OTP_MODE_ENTER_CMD: begin
               if (plain)
                  otp_q <= 1'b1; // see RQ20
            end
            `SFG_OTP_MODE_EXIT_CMD: begin
               if (plain)
                  otp_q <= 1'b0;
            end
            `SFG_SECURITY_REG_WRITE_CMD: begin
               if (plain && latch_q)
                  cust_q <= 1'b1; // see RQ21 RQ22
            end
            default: ;
            endcase
         end
         if (!cs_hi) begin
            case (ph_q)
            P_OPC: begin
               if (done) begin
                  opc_q <= nb;
                  // A status poll must not wipe the marks of a running program
                  if (!busy_q)
                     pval_q <= 256'h0; // see RQ27
                  if (sleep_q && nb != `SFG_WAKE_FROM_SLEEP_CMD)
                     ph_q <= P_IGN; // see RQ12
                  else if (busy_q && nb != `SFG_STATUS_READ_CMD)
                     ph_q <= P_IGN; // see RQ27
                  else begin
                     case (nb)
                     `SFG_STATUS_READ_CMD, `SFG_SECURITY_REG_READ_CMD: begin
                        ph_q <= P_DOUT;
                        ocnt_q <= 4'h0;
                     end
                     `SFG_READ_CMD, `SFG_PAGE_PROGRAM_CMD, `SFG_FOUR_KB_WIPE_CMD,
                     `SFG_BLOCK_WIPE_CMD, `SFG_WAKE_FROM_SLEEP_CMD:
                        ph_q <= P_ADDR;
                     `SFG_DUAL_READ_CMD: begin
                        ph_q <= P_ADDR;
                        lanes_q <= 3'h2; // see RQ2
                     end
                     `SFG_QUAD_READ_CMD, `SFG_QUAD_PAGE_PROGRAM_CMD: begin
                        ph_q <= P_ADDR;
                        lanes_q <= 3'h4; // see RQ3
                     end
                     `SFG_SET_WRITE_ENABLE_CMD, `SFG_CLEAR_WRITE_ENABLE_CMD,
                     `SFG_STATUS_WRITE_CMD, `SFG_CHIP_WIPE_CMD, `SFG_DEEP_SLEEP_CMD,
                     `SFG_OTP_MODE_ENTER_CMD, `SFG_OTP_MODE_EXIT_CMD,
                     `SFG_SECURITY_REG_WRITE_CMD:
                        ph_q <= P_DIN;
                     default: ph_q <= P_IGN; // see RQ26
                     endcase
                  end
               end
            end
            P_ADDR: begin
               if (done) begin
                  addr_q <= full_addr;
                  abytes_q <= abytes_q + 2'h1;
                  if (abytes_q == 2'h2) begin
                     raddr_q <= full_addr;
                     ocnt_q <= 4'h0;
                     col_q <= nb;
                     case (opc_q)
                     `SFG_DUAL_READ_CMD: begin
                        ph_q <= P_DUMMY;
                        dcnt_q <= `SFG_DUAL_DUMMY;
                     end
                     `SFG_QUAD_READ_CMD: begin
                        ph_q <= P_DUMMY;
                        dcnt_q <= `SFG_QUAD_DUMMY;
                     end
                     `SFG_READ_CMD, `SFG_WAKE_FROM_SLEEP_CMD: ph_q <= P_DOUT;
                     default: ph_q <= P_DIN;
                     endcase
                  end
               end
            end
            P_DUMMY: begin
               if (rise) begin
                  dcnt_q <= dcnt_q - 3'h1;
                  if (dcnt_q == 3'h1)
                     ph_q <= P_DOUT;
               end
            end
            P_DIN: begin
               if (done) begin
                  nin_q <= 1'b1;
                  if (!nin_q)
                     sdat_q <= nb;
                  if (prog_cmd) begin
                     // Column wraps inside the page
                     pval_q[col_q] <= 1'b1;
                     col_q <= col_q + 8'h01;
                  end
               end
            end
            P_DOUT: begin
               if (fall) begin // see RQ25
                  osh_q <= (lanes_q == 3'h1) ? {obyte[6:0], 1'b0} :
                           (lanes_q == 3'h2) ? {obyte[5:0], 2'h0} : {obyte[3:0], 4'h0};
                  ocnt_q <= ocur - {1'b0, lanes_q};
                  if (ocnt_q == 4'h0)
                     raddr_q <= raddr_q + 24'h000001;
                  o_io_line1_oe <= 1'b1;
                  o_io_line0_oe <= lanes_q != 3'h1; // see RQ2
                  o_io_line2_oe <= lanes_q == 3'h4; // see RQ3
                  o_io_line3_oe <= lanes_q == 3'h4;
                  case (lanes_q)
                  3'h1: o_io_line1_out <= obyte[7];
                  3'h2: begin
                     o_io_line1_out <= obyte[7];
                     o_io_line0_out <= obyte[6];
                  end
                  default: begin
                     o_io_line3_out <= obyte[7];
                     o_io_line2_out <= obyte[6];
                     o_io_line1_out <= obyte[5];
                     o_io_line0_out <= obyte[4];
                  end
                  endcase
               end
            end
            default: ;
            endcase
         end
      end
   end

   // Wishbone slave; answers every address, one ack per request
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
         quad_en_q <= 1'b0;
         fact_q <= 1'b0;
      end else begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
         if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            case (i_wb_adr)
            `SFG_STATUS_OFS:
               o_wb_dat <= {19'h00000, cust_q, fact_q, o_standby, sleep_q, otp_q, stat};
            `SFG_CTRL_OFS: o_wb_dat <= {30'h00000000, fact_q, quad_en_q};
            default: o_wb_dat <= 32'h00000000;
            endcase
         end
         // Write lands on the edge at which the master sees ack
         if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0] &&
             i_wb_adr == `SFG_CTRL_OFS) begin
            quad_en_q <= i_wb_dat[`SFG_CTRL_QUAD_EN]; // see RQ18
            if (i_wb_dat[`SFG_CTRL_FACTORY_LOCK])
               fact_q <= 1'b1; // see RQ22
         end
      end
   end
endmodule // sfg_write_guard

// ---- hw/sfg_map.vh ----
// Constants of the serial flash write guard: opcodes, bit positions, offsets.
// Assumes one inclusion per design file; holds definitions only.
// Overview of operation
// RQ1 - The array holds 2,097,152 bytes whatever the line width used.
// RQ2 - Dual read turns lines 0 and 1 into two-way address and data lines.
// RQ3 - Quad read also uses lines 2 and 3 as two-way lines.
// RQ4 - Program works on page-buffered bytes; erase on 4K, 64K or whole array.
// RQ5 - A write-in-progress bit in status shows a running program or erase.
// RQ6 - With select high and nothing running, the device sits in standby.
// RQ7 - Reset puts the command machine in standby without host action.
// RQ8 - Storage changes only after a complete, well-formed command is accepted.
// RQ9 - Data-changing commands must end exactly on a byte boundary.
// RQ10 - Data-changing commands need the write enable latch set first.
// RQ11 - The latch clears at reset and after clear, status write, program, erase.
// RQ12 - In deep sleep only wake and signature read are accepted.
// RQ13 - Blocks selected by the protection level field refuse program and erase.
// RQ14 - Levels 1 to 5 protect the top 1, 2, 4, 8, 16 blocks.
// RQ15 - Levels 10 to 14 protect the bottom 16, 24, 28, 30, 31 blocks.
// RQ16 - Level 0 protects nothing; levels 6 to 9 and 15 protect all.
// RQ17 - Pin protect mode guards protection level bits and status lock bit.
// RQ18 - Quad mode disables pin protection since line 2 carries data.
// RQ19 - Security register bit 0 shows the factory lock of the one-time area.
// RQ20 - One-time area is programmed between enter and exit commands.
// RQ21 - Security register write sets customer lock bit 1.
// RQ22 - Set locks never clear and locked one-time contents never change; the code clears cust_q and fact_q at reset.
// RQ23 - While one-time mode is active the main array is not reachable.
// RQ24 - One-time offsets 000-00F hold the factory serial, 010-1FF customer data.
// RQ25 - Inputs captured on rising serial clock, outputs shifted on falling.
// RQ26 - Unknown command: standby, lines released until next select fall.
// RQ27 - While busy, array access attempts are ignored without disturbance.
// RQ28 - Data-changing command with latch clear changes nothing.
`ifndef SFG_MAP_VH
`define SFG_MAP_VH
`define SFG_SET_WRITE_ENABLE_CMD 8'h06
`define SFG_CLEAR_WRITE_ENABLE_CMD 8'h04
`define SFG_STATUS_READ_CMD 8'h05
`define SFG_STATUS_WRITE_CMD 8'h01
`define SFG_READ_CMD 8'h03
`define SFG_DUAL_READ_CMD 8'hBB
`define SFG_QUAD_READ_CMD 8'hEB
`define SFG_PAGE_PROGRAM_CMD 8'h02
`define SFG_QUAD_PAGE_PROGRAM_CMD 8'h38
`define SFG_FOUR_KB_WIPE_CMD 8'h20
`define SFG_BLOCK_WIPE_CMD 8'hD8
`define SFG_CHIP_WIPE_CMD 8'hC7
`define SFG_DEEP_SLEEP_CMD 8'hB9
`define SFG_WAKE_FROM_SLEEP_CMD 8'hAB
`define SFG_OTP_MODE_ENTER_CMD 8'hB1
`define SFG_OTP_MODE_EXIT_CMD 8'hC1
`define SFG_SECURITY_REG_READ_CMD 8'h2B
`define SFG_SECURITY_REG_WRITE_CMD 8'h2F
`define SFG_DUAL_DUMMY 3'h4
`define SFG_QUAD_DUMMY 3'h6
`define SFG_SIGNATURE 8'h5A // Arbitrary value
`define SFG_ARRAY_BYTES 2097152
`define SFG_OTP_BYTES 512
`define SFG_PAGE_BYTES 256
`define SFG_SERIAL_LAST 9'h00F
`define SFG_ERASED 8'hFF
`define SFG_SECTOR_MASK 24'h000FFF
`define SFG_BLOCK_MASK 24'h00FFFF
`define SFG_CHIP_LAST 24'h1FFFFF
`define SFG_BP_RESET 4'h0
`define SFG_STATUS_OFS 8'h00
`define SFG_CTRL_OFS 8'h04
`define SFG_CTRL_QUAD_EN 0
`define SFG_CTRL_FACTORY_LOCK 1
`endif

// ---- verif/sfg_write_guard_chk.sv ----
// Checker of the write guard: bus handshake, select, busy and line drive.
// Assumes a bind to sfg_write_guard; sees only its ports.
`timescale 1ns/1ps
module sfg_write_guard_chk (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_cs_b,
   input wire logic o_io_line1_oe,
   input wire logic o_write_in_progress,
   input wire logic o_standby
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire eng_busy = o_write_in_progress;
   a_ack_after_req: assert property (req |=> o_wb_ack)
      else $error("no ack after request");
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");
   a_ack_cause: assert property (o_wb_ack |-> $past(req))
      else $error("ack without request");
   a_rdata_held: assert property (!req |=> $stable(o_wb_dat))
      else $error("read data moved");
   a_select_wakes: assert property (!i_cs_b [*4] |-> !o_standby)
      else $error("standby while selected");
   a_busy_no_standby: assert property ($rose(eng_busy) |=> !o_standby [*2])
      else $error("standby while busy");
   a_busy_after_frame: assert property ($rose(eng_busy) |-> i_cs_b && $past(i_cs_b, 2))
      else $error("busy began inside a frame");
   a_busy_span: assert property ($rose(eng_busy) |-> eng_busy [*8])
      else $error("busy too short");
   a_idle_release: assert property (i_cs_b [*8] |-> !o_io_line1_oe)
      else $error("line driven while deselected");
   a_drive_selected: assert property ($rose(o_io_line1_oe) |-> !i_cs_b)
      else $error("drive began while deselected");
   c_busy_end: cover property ($fell(eng_busy));
   c_drive: cover property ($rose(o_io_line1_oe));
   c_bus: cover property (req ##1 o_wb_ack);
endmodule // sfg_write_guard_chk

bind sfg_write_guard sfg_write_guard_chk i_chk (.i_clk, .i_rst_b, .i_wb_cyc, .i_wb_stb,
   .o_wb_dat, .o_wb_ack, .i_cs_b, .o_io_line1_oe, .o_write_in_progress, .o_standby);

// ---- verif/sfg_host_model.sv ----
// Host link model: a mode 0 master sending frames, shifting answers in.
// Assumes the bench fills tx and calls xfer; link period 48 ns.
`timescale 1ns/1ps
module sfg_host_model (
   output logic o_cs_b,
   output logic o_sclk,
   output logic o_mosi,
   input wire logic i_miso
);
   logic [7:0] tx [0:4];
   logic [15:0] rx;
   initial begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // Clock idles low outside frames; bits set while low, taken on the rise
   task automatic xfer(input int nb, input int nr);
      for (int i = 0; i < nb + 8 * nr; i++) begin
         o_cs_b = 1'b0;
         o_mosi = (i < nb) ? tx[i / 8][7 - i % 8] : ~o_mosi;
         #24 o_sclk = 1'b1;
         if (i >= nb) rx = {rx[14:0], i_miso};
         #24 o_sclk = 1'b0;
      end
      #24 o_cs_b = 1'b1;
      o_mosi = ~o_mosi; // Released line shows no stale bit
      #48; // Deselect for one link period
   endtask
endmodule // sfg_host_model

// ---- verif/sfg_write_guard_tb.sv ----
// Bench for the write guard: status polled over Wishbone, host link model.
// Assumes sfg_write_guard and sfg_host_model; ends in final_report.
`timescale 1ns/1ps
module sfg_write_guard_tb;
   logic i_clk, i_rst_b, cyc, stb, we, wp;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   wire [31:0] o_wb_dat;
   wire ack, cs_b, sclk, mosi;
   wire [3:0] out, oe;
   wire l0 = oe[0] ? out[0] : mosi;
   wire l1 = oe[1] ? out[1] : 1'b1; // Pulled up while released
   wire l2 = oe[2] ? out[2] : wp;
   wire l3 = oe[3] ? out[3] : 1'b1;
   int n_fail = 0;
   int n_tests = 0;
   logic [39:0] rows [0:14] = '{40'h0600_08_0402, 40'h0400_08_0400, 40'h0600_07_0400,
      40'h0600_08_0402, 40'h010C_0F_0402, 40'h010C_10_040C, 40'h0100_10_040C,
      40'hB900_08_060C, 40'h0600_08_060C, 40'hAB00_08_040C, 40'hB100_08_050C,
      40'hC100_08_040C, 40'h0600_08_040E, 40'h2F00_08_140E, 40'h0400_08_140C};
   sfg_write_guard i_dut (.i_clk, .i_rst_b, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat, .o_wb_ack(ack),
      .i_cs_b(cs_b), .i_sclk(sclk), .i_io_line0_in(l0), .i_io_line1_in(l1),
      .i_io_line2_in(l2), .i_io_line3_in(l3), .o_io_line0_out(out[0]),
      .o_io_line1_out(out[1]), .o_io_line2_out(out[2]), .o_io_line3_out(out[3]),
      .o_io_line0_oe(oe[0]), .o_io_line1_oe(oe[1]), .o_io_line2_oe(oe[2]),
      .o_io_line3_oe(oe[3]), .o_write_in_progress(), .o_standby());
   sfg_host_model i_host (.o_cs_b(cs_b), .o_sclk(sclk), .o_mosi(mosi), .i_miso(l1));
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      if (t == 20) n_fail++;
      rdat = o_wb_dat; // Taken at the ack edge
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Busy polled first: commands sent while busy would be ignored
   task automatic st_chk(input logic [31:0] e);
      int t;
      t = 0;
      do begin
         wb(1'b0, 8'h00, 32'h0);
         t++;
      end while (rdat[0] !== 1'b0 && t < 9000);
      chk("status", e, rdat);
   endtask
   task automatic spi(input logic [39:0] d, input int nb, input int nr);
      for (int i = 0; i < 5; i++) i_host.tx[i] = d[39 - 8 * i -: 8];
      i_host.xfer(nb, nr);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      final_report;
   end
   initial begin
      {cyc, stb, we, adr, wdat} = '0;
      wp = 1'b1;
      i_rst_b = 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      wb(1'b0, 8'h00, 32'h0);
      chk("status", 32'h0400, rdat);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rdat);
      $display("test reset over");
      foreach (rows[k]) begin
         spi({rows[k][39:24], 24'h0}, rows[k][23:16], 0);
         st_chk({16'h0, rows[k][15:0]});
      end
      $display("test commands over");
      spi({8'h06, 32'h0}, 8, 0);
      spi({8'h02, 24'h1C0000, 8'hA5}, 40, 0);
      st_chk(32'h140E);
      spi({8'h20, 24'h1B0000, 8'h00}, 32, 0);
      st_chk(32'h140C);
      spi({8'h06, 32'h0}, 8, 0);
      spi({8'h02, 24'h1B0010, 8'h5A}, 40, 0);
      st_chk(32'h140C);
      spi({8'h03, 24'h1B0010, 8'h00}, 32, 2);
      chk("read", 32'h5AFF, {16'h0, i_host.rx});
      $display("test protect over");
      spi({8'h06, 32'h0}, 8, 0);
      spi({16'h018C, 24'h0}, 16, 0);
      st_chk(32'h148C);
      wp <= 1'b0;
      spi({8'h06, 32'h0}, 8, 0);
      spi({16'h0100, 24'h0}, 16, 0);
      st_chk(32'h148E);
      wb(1'b1, 8'h04, 32'h1);
      spi({16'h0100, 24'h0}, 16, 0);
      st_chk(32'h1400);
      wp <= 1'b1;
      $display("test pin over");
      wb(1'b1, 8'h04, 32'h2);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b0, 8'h04, 32'h0);
      chk("ctrl", 32'h2, rdat);
      st_chk(32'h1C00);
      $display("test lock over");
      final_report;
   end
endmodule // sfg_write_guard_tb
